// ===== dram_mode_word_config.sv
`timescale 1ns/10ps

// ****************************************************************
// Mode word configuration of the memory device.
// ****************************************************************

// Operation
// - Writes work unlocked; write termination needs lock
// - Driver strength from second word bits 2:1
// - Nominal, write and park termination values
// - Write termination applies despite nominal off
// - Commands held by added latency internally
// - Latencies are added latency plus CAS delays
// - Added latency decodes zero, CL-1, CL-2
// - Equalizer code taken from bits 13,6,5
// - Bit 12 disables drivers and nominal, write and park termination
// - Strobe termination reaches strobe pins otherwise
// - Strobe termination excludes masking and inversion
// - Bits 20:18 select word; 111 forbidden
// - Third word bit 12 enables CRC
// - Driver strength 34 or 48 ohm
// - Second word bit 11 enables strobe termination
// - Second word bit 7 enters write leveling
module dram_mode_word_config
  import mode_word_pkg::*;
#(
  parameter int MAX_AL = 31,
  parameter bit HAS_STROBE_TERM_PINS = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ck,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_act_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [1:0] i_bg,
  input wire logic [1:0] i_ba,
  input wire logic [17:0] i_addr,
  input wire logic i_termination_enable_pin,
  input wire logic [4:0] i_read_cas_delay,
  input wire logic [4:0] i_write_cas_delay,
  output logic [WORD_W-1:0] o_second_mode_word,
  output logic [WORD_W-1:0] o_third_mode_word,
  output logic [WORD_W-1:0] o_sixth_mode_word,
  output logic o_dll_enable,
  output logic [1:0] o_driver_strength,
  output logic [5:0] o_driver_ohm,
  output logic o_driver_enable,
  output logic [4:0] o_added_latency,
  output logic [5:0] o_read_latency,
  output logic [5:0] o_write_latency,
  output logic [2:0] o_receiver_equalizer,
  output logic o_write_level,
  output logic o_crc_enable,
  output logic o_strobe_term_en,
  output logic o_strobe_pin_term_en,
  output logic o_byte_write_mask_en,
  output logic o_write_inv_en,
  output logic o_read_inv_en,
  output logic [3:0] o_term_src,
  output logic [2:0] o_term_code,
  output logic o_rd_issue,
  output logic o_wr_issue,
  output logic o_forbidden_load
);

  // ****************************************************************
  // Pin synchronisation.
  // ****************************************************************

  localparam int PIN_W = 30; // Clock, gate, five command lines, 22 word bits, termination pin.

  logic [PIN_W-1:0] pins_raw; // Pin bundle before synchronisation.
  logic [PIN_W-1:0] pins; // Pin bundle after synchronisation.

  assign pins_raw = {i_ck, i_cke, i_cs_n, i_act_n, i_ras_n, i_cas_n, i_we_n,
                     i_bg, i_ba, i_addr, i_termination_enable_pin};

  // All pins pass three stages and the level register in step, keeping fields aligned.
  pin_sync #(
    .W(PIN_W)
  ) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_pin(pins_raw),
    .o_level(pins)
  );

  logic ck_s; // Synchronised link clock.
  logic cs_n_s; // Synchronised chip select.
  logic act_n_s; // Synchronised activate line.
  logic ras_n_s; // Synchronised row line.
  logic cas_n_s; // Synchronised column line.
  logic we_n_s; // Synchronised write strobe line.
  logic [WORD_W-1:0] word_s; // Word carried by bank-group, bank and address pins.
  logic term_pin_s; // Synchronised termination enable pin.

  assign ck_s = pins[29];
  assign cs_n_s = pins[27];
  assign act_n_s = pins[26];
  assign ras_n_s = pins[25];
  assign cas_n_s = pins[24];
  assign we_n_s = pins[23];
  assign term_pin_s = pins[0];

  // Command lines share address positions 16:14; they are stored as zero.
  always_comb begin
    word_s = {pins[22:19], pins[18:1]};
    word_s[CMD_LINES_HI:CMD_LINES_LO] = 3'h0;
  end

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Takes a three-bit field out of a mode word.
  function automatic logic [2:0] field3(input logic [WORD_W-1:0] w, input int lo);
    field3 = w[lo+:3];
  endfunction : field3

  // Maps a driver strength code to ohms; reserved codes give zero.
  function automatic logic [5:0] drv_ohm(input logic [1:0] code);
    case (code)
      DRV_34: drv_ohm = OHM_34;
      DRV_48: drv_ohm = OHM_48;
      default: drv_ohm = 6'h00;
    endcase
  endfunction : drv_ohm

  // ****************************************************************
  // State.
  // ****************************************************************

  typedef struct packed {
    logic ck_prev; // Link clock level at the previous system edge.
    logic [WORD_W-1:0] second; // Second mode word.
    logic [WORD_W-1:0] third; // Third mode word.
    logic [WORD_W-1:0] sixth; // Sixth mode word.
    logic forbidden; // Pulse on a load using the forbidden select code.
    logic [2:0] wr_term_cnt; // Link edges of write termination left.
    term_src_t src; // Termination source applied.
    logic [2:0] term; // Termination code applied.
  } cfg_st_t;

  cfg_st_t st_q; // Registered state.
  cfg_st_t st_d; // Next state.

  initial begin
    if (MAX_AL < 1 || MAX_AL > 31) begin
      $error("MAX_AL must lie in 1..31");
    end
  end

  // ****************************************************************
  // Command decode.
  // ****************************************************************

  logic ck_rise; // One-cycle pulse at a rising link clock edge.
  logic cmd_sel; // Chip selected and not an activate.
  logic is_load; // Mode load command seen at this edge.
  logic is_rd; // Read command seen at this edge.
  logic is_wr; // Write command seen at this edge.
  logic [4:0] al; // Added latency in link clock cycles.
  logic rd_go; // Read released after the added latency.
  logic wr_go; // Write released after the added latency.
  logic dll_on; // Delay-locked loop enabled.

  assign ck_rise = ck_s & ~st_q.ck_prev;
  assign cmd_sel = ck_rise & ~cs_n_s & act_n_s;
  assign is_load = cmd_sel & ~ras_n_s & ~cas_n_s & ~we_n_s;
  assign is_rd = cmd_sel & ras_n_s & ~cas_n_s & we_n_s;
  assign is_wr = cmd_sel & ras_n_s & ~cas_n_s & ~we_n_s;
  assign dll_on = st_q.second[DLL_EN_BIT];

  // Added latency follows the read CAS delay; the reserved code acts as zero.
  always_comb begin
    case (st_q.second[AL_HI:AL_LO])
      AL_MINUS1: al = i_read_cas_delay - 5'h01;
      AL_MINUS2: al = i_read_cas_delay - 5'h02;
      default: al = 5'h00;
    endcase
  end

  // Reads and writes wait the added latency, counted in link clock edges; one whose delay exceeds MAX_AL is dropped.
  cmd_delay_line #(
    .MAX_DELAY(MAX_AL)
  ) u_cmd_delay_line (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_step(ck_rise),
    .i_rd(is_rd),
    .i_wr(is_wr),
    .i_delay(al),
    .o_rd(rd_go),
    .o_wr(wr_go)
  );

  // ****************************************************************
  // Next state.
  // ****************************************************************

  // Stores loads, tracks write termination and picks the applied termination.
  always_comb begin
    logic [2:0] nom;
    logic [2:0] wrt;
    logic [2:0] park;
    nom = field3(st_q.second, NOM_LO);
    wrt = field3(st_q.third, WR_TERM_LO);
    park = field3(st_q.sixth, PARK_LO);
    st_d = st_q;
    st_d.ck_prev = ck_s;
    st_d.forbidden = 1'b0;
    // A load updates only the word it selects; other words keep their value.
    if (is_load) begin
      case (word_s[SEL_HI:SEL_LO])
        SEL_SECOND: st_d.second = word_s;
        SEL_THIRD: st_d.third = word_s;
        SEL_SIXTH: st_d.sixth = word_s;
        SEL_FORBIDDEN: st_d.forbidden = 1'b1;
        default: st_d.forbidden = 1'b0;
      endcase
    end
    // Write termination needs the loop locked; it counts on link edges.
    if (wr_go && dll_on && wrt != TERM_OFF) begin
      st_d.wr_term_cnt = 3'(WR_TERM_EDGES);
    end else if (ck_rise && st_q.wr_term_cnt != 3'h0) begin
      st_d.wr_term_cnt = st_q.wr_term_cnt - 3'h1;
    end
    // Output disable removes nominal, write and park termination, not strobe termination; write wins over nominal and park.
    if (st_q.second[OUT_OFF_BIT]) begin
      st_d.src = TS_NONE;
      st_d.term = TERM_OFF;
    end else if (st_q.wr_term_cnt != 3'h0) begin
      st_d.src = TS_WRITE;
      st_d.term = wrt;
    end else if (!term_pin_s) begin
      st_d.src = (park == TERM_OFF) ? TS_NONE : TS_PARK;
      st_d.term = park;
    end else begin
      st_d.src = (nom == TERM_OFF) ? TS_NONE : TS_NOM;
      st_d.term = nom;
    end
  end

  // Registers the state; synchronous active-low reset.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_q.ck_prev <= 1'b0;
      st_q.second <= WORD_RESET;
      st_q.third <= WORD_RESET;
      st_q.sixth <= WORD_RESET;
      st_q.forbidden <= 1'b0;
      st_q.wr_term_cnt <= 3'h0;
      st_q.src <= TS_NONE;
      st_q.term <= TERM_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************

  logic strobe_term; // Extra strobe termination enabled.

  assign strobe_term = st_q.second[STROBE_TERM_BIT];

  assign o_second_mode_word = st_q.second;
  assign o_third_mode_word = st_q.third;
  assign o_sixth_mode_word = st_q.sixth;
  assign o_dll_enable = dll_on;
  assign o_driver_strength = st_q.second[DRV_HI:DRV_LO];
  assign o_driver_ohm = drv_ohm(st_q.second[DRV_HI:DRV_LO]);
  assign o_driver_enable = ~st_q.second[OUT_OFF_BIT];
  assign o_added_latency = al;
  assign o_read_latency = {1'b0, al} + {1'b0, i_read_cas_delay};
  assign o_write_latency = {1'b0, al} + {1'b0, i_write_cas_delay};
  assign o_receiver_equalizer = {st_q.second[EQ_BIT2], st_q.second[EQ_BIT1],
                                 st_q.second[EQ_BIT0]};
  assign o_write_level = st_q.second[WLEV_BIT];
  assign o_crc_enable = st_q.third[CRC_EN_BIT];
  assign o_strobe_term_en = strobe_term & HAS_STROBE_TERM_PINS;
  assign o_strobe_pin_term_en = strobe_term & ~HAS_STROBE_TERM_PINS;
  // Shared pin: strobe termination blocks all; masking beats write inversion.
  assign o_byte_write_mask_en = ~strobe_term & st_q.sixth[MASK_EN_BIT];
  assign o_write_inv_en = ~strobe_term & ~st_q.sixth[MASK_EN_BIT]
                          & st_q.sixth[WR_INV_BIT];
  assign o_read_inv_en = ~strobe_term & st_q.sixth[RD_INV_BIT];
  assign o_term_src = st_q.src;
  assign o_term_code = st_q.term;
  assign o_rd_issue = rd_go;
  assign o_wr_issue = wr_go;
  assign o_forbidden_load = st_q.forbidden;

endmodule : dram_mode_word_config

// ===== mode_word_pkg.sv
package mode_word_pkg;

  // ****************************************************************
  // Mode word layout.
  // ****************************************************************

  // Mode word width on the bank-group, bank and address pins.
  localparam int WORD_W = 22;
  // Target word select field.
  localparam int SEL_HI = 20;
  localparam int SEL_LO = 18;
  // Target word codes.
  localparam logic [2:0] SEL_SECOND = 3'h1;
  localparam logic [2:0] SEL_THIRD = 3'h2;
  localparam logic [2:0] SEL_SIXTH = 3'h5;
  localparam logic [2:0] SEL_FORBIDDEN = 3'h7;
  // Command line positions in the pin word; stored as zero.
  localparam int CMD_LINES_HI = 16;
  localparam int CMD_LINES_LO = 14;

  // ****************************************************************
  // Second mode word fields.
  // ****************************************************************

  localparam int DLL_EN_BIT = 0;
  localparam int DRV_HI = 2;
  localparam int DRV_LO = 1;
  localparam int AL_HI = 4;
  localparam int AL_LO = 3;
  localparam int EQ_BIT2 = 13;
  localparam int EQ_BIT1 = 6;
  localparam int EQ_BIT0 = 5;
  localparam int WLEV_BIT = 7;
  localparam int NOM_HI = 10;
  localparam int NOM_LO = 8;
  localparam int STROBE_TERM_BIT = 11;
  localparam int OUT_OFF_BIT = 12;

  // ****************************************************************
  // Third and sixth mode word fields.
  // ****************************************************************

  localparam int WR_TERM_HI = 11;
  localparam int WR_TERM_LO = 9;
  localparam int CRC_EN_BIT = 12;
  localparam int PARK_HI = 8;
  localparam int PARK_LO = 6;
  localparam int MASK_EN_BIT = 10;
  localparam int WR_INV_BIT = 11;
  localparam int RD_INV_BIT = 12;

  // ****************************************************************
  // Codes and reset values.
  // ****************************************************************

  // Reset value of every mode word.
  localparam logic [WORD_W-1:0] WORD_RESET = 22'h000000;
  // Termination code meaning off.
  localparam logic [2:0] TERM_OFF = 3'h0;
  // Added latency codes.
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_MINUS1 = 2'h1;
  localparam logic [1:0] AL_MINUS2 = 2'h2;
  // Driver strength codes.
  localparam logic [1:0] DRV_34 = 2'h0;
  localparam logic [1:0] DRV_48 = 2'h1;
  // Driver strength in ohms.
  localparam logic [5:0] OHM_34 = 6'h22;
  localparam logic [5:0] OHM_48 = 6'h30;
  // Link clock edges of write termination per write.
  localparam int WR_TERM_EDGES = 4;

  // Source of the termination currently applied.
  typedef enum logic [3:0] {
    TS_NONE = 4'h1,
    TS_PARK = 4'h2,
    TS_NOM = 4'h4,
    TS_WRITE = 4'h8
  } term_src_t;

endpackage : mode_word_pkg

// ===== pin_sync.sv
`timescale 1ns/10ps

// Three-stage synchroniser for pins; a level counts once stages two and three agree.
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);

  // ****************************************************************
  // State.
  // ****************************************************************

  // All stages plus the accepted level.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_st_t;

  sync_st_t st_q; // Registered state.
  sync_st_t st_d; // Next state.

  // Shifts the stages and takes bits on which stages two and three agree.
  always_comb begin
    st_d = st_q;
    st_d.s1 = i_pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  // Registers the state; synchronous active-low reset.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_level = st_q.lvl;

endmodule : pin_sync

// ===== cmd_delay_line.sv
`timescale 1ns/10ps

// Holds read and write commands for a chosen number of link clock edges.
module cmd_delay_line #(
  parameter int MAX_DELAY = 31
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_step,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [4:0] i_delay,
  output logic o_rd,
  output logic o_wr
);

  // ****************************************************************
  // State.
  // ****************************************************************

  typedef struct packed {
    logic [MAX_DELAY-1:0] rd_sh;
    logic [MAX_DELAY-1:0] wr_sh;
    logic rd_out;
    logic wr_out;
  } dly_st_t;

  dly_st_t st_q; // Registered state.
  dly_st_t st_d; // Next state.

  initial begin
    if (MAX_DELAY < 1 || MAX_DELAY > 31) begin
      $error("MAX_DELAY must lie in 1..31");
    end
  end

  // On each step, slots move one closer; a new command lands at its delay slot.
  always_comb begin
    st_d = st_q;
    st_d.rd_out = 1'b0;
    st_d.wr_out = 1'b0;
    if (i_step) begin
      st_d.rd_sh = st_q.rd_sh >> 1;
      st_d.wr_sh = st_q.wr_sh >> 1;
      if (i_delay == 5'h00) begin
        st_d.rd_out = st_q.rd_sh[0] | i_rd;
        st_d.wr_out = st_q.wr_sh[0] | i_wr;
      end else begin
        st_d.rd_out = st_q.rd_sh[0];
        st_d.wr_out = st_q.wr_sh[0];
        if (int'(i_delay) <= MAX_DELAY) begin
          st_d.rd_sh[i_delay-5'h01] = st_d.rd_sh[i_delay-5'h01] | i_rd;
          st_d.wr_sh[i_delay-5'h01] = st_d.wr_sh[i_delay-5'h01] | i_wr;
        end
      end
    end
  end

  // Registers the state; synchronous active-low reset.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rd = st_q.rd_out;
  assign o_wr = st_q.wr_out;

endmodule : cmd_delay_line

// ===== mode_word_checker.sv
`timescale 1ns/10ps

// ****************************************************************
// Port checker for the mode word block.
// ****************************************************************
module mode_word_checker
  import mode_word_pkg::*;
#(
  parameter int MAX_AL = 31,
  parameter bit HAS_STROBE_TERM_PINS = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [4:0] i_read_cas_delay,
  input wire logic [4:0] i_write_cas_delay,
  input wire logic [WORD_W-1:0] o_second_mode_word,
  input wire logic [WORD_W-1:0] o_third_mode_word,
  input wire logic [WORD_W-1:0] o_sixth_mode_word,
  input wire logic o_dll_enable,
  input wire logic [1:0] o_driver_strength,
  input wire logic [5:0] o_driver_ohm,
  input wire logic o_driver_enable,
  input wire logic [4:0] o_added_latency,
  input wire logic [5:0] o_read_latency,
  input wire logic [5:0] o_write_latency,
  input wire logic [2:0] o_receiver_equalizer,
  input wire logic o_write_level,
  input wire logic o_crc_enable,
  input wire logic o_strobe_term_en,
  input wire logic o_strobe_pin_term_en,
  input wire logic o_byte_write_mask_en,
  input wire logic o_write_inv_en,
  input wire logic o_read_inv_en,
  input wire logic [3:0] o_term_src,
  input wire logic o_wr_issue,
  input wire logic o_forbidden_load
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_drive_field: assert property (
    o_driver_strength == o_second_mode_word[DRV_HI:DRV_LO] && o_driver_ohm ==
    (o_driver_strength == DRV_34 ? OHM_34 : o_driver_strength == DRV_48 ? OHM_48 : 6'h00))
    else $error("driver strength decode wrong");
  a_added_latency: assert property (o_added_latency ==
    (o_second_mode_word[AL_HI:AL_LO] == AL_MINUS1 ? i_read_cas_delay - 5'h01 :
    o_second_mode_word[AL_HI:AL_LO] == AL_MINUS2 ? i_read_cas_delay - 5'h02 : 5'h00))
    else $error("added latency decode wrong");
  a_latency_sum: assert property (
    o_read_latency == {1'b0, o_added_latency} + {1'b0, i_read_cas_delay} &&
    o_write_latency == {1'b0, o_added_latency} + {1'b0, i_write_cas_delay})
    else $error("latency sum wrong");
  a_equalizer_bits: assert property (o_receiver_equalizer ==
    {o_second_mode_word[EQ_BIT2], o_second_mode_word[EQ_BIT1], o_second_mode_word[EQ_BIT0]})
    else $error("equalizer code wrong");
  a_level_bit: assert property (o_write_level == o_second_mode_word[WLEV_BIT])
    else $error("write leveling bit wrong");
  a_output_off: assert property (
    o_second_mode_word[OUT_OFF_BIT] ##1 o_second_mode_word[OUT_OFF_BIT]
    |-> !o_driver_enable && o_term_src == TS_NONE)
    else $error("outputs not disconnected");
  a_strobe_matrix: assert property (
    (o_strobe_term_en |-> !o_byte_write_mask_en && !o_write_inv_en && !o_read_inv_en)
    and !(o_byte_write_mask_en && o_write_inv_en))
    else $error("shared pin functions clash");
  a_strobe_route: assert property (
    o_strobe_term_en == o_second_mode_word[STROBE_TERM_BIT] && !o_strobe_pin_term_en)
    else $error("strobe termination routing wrong");
  a_crc_follow: assert property (o_crc_enable == o_third_mode_word[CRC_EN_BIT])
    else $error("crc enable wrong");
  a_forbidden_hold: assert property (o_forbidden_load |->
    $stable(o_second_mode_word) && $stable(o_third_mode_word) && $stable(o_sixth_mode_word))
    else $error("forbidden load changed a word");
  a_select_field: assert property (
    (o_second_mode_word != WORD_RESET |-> o_second_mode_word[SEL_HI:SEL_LO] == SEL_SECOND)
    and (o_third_mode_word != WORD_RESET |-> o_third_mode_word[SEL_HI:SEL_LO] == SEL_THIRD))
    else $error("stored select field wrong");
  a_write_term: assert property (
    o_wr_issue && o_dll_enable && o_third_mode_word[WR_TERM_HI:WR_TERM_LO] != TERM_OFF
    && !o_second_mode_word[OUT_OFF_BIT] |-> ##[1:3] o_term_src == TS_WRITE)
    else $error("write termination not applied");
endmodule : mode_word_checker

bind dram_mode_word_config mode_word_checker #(
  .MAX_AL(MAX_AL),
  .HAS_STROBE_TERM_PINS(HAS_STROBE_TERM_PINS)
) u_checker (.*);

// ===== mode_load_controller.sv
`timescale 1ns/10ps

// ****************************************************************
// Controller model: makes the link clock and drives command pins.
// ****************************************************************
module mode_load_controller (
  input wire logic i_clk_sys,
  output logic o_ck,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_act_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [1:0] o_bg,
  output logic [1:0] o_ba,
  output logic [17:0] o_addr
);
  int edges = 0; // Link rising edges so far.
  int cmd_edge = 0; // Edge number that carried the latest command.

  // Link clock, free running and unrelated in phase to the system clock.
  initial begin
    o_ck = 1'b0;
    #37;
    forever #100 o_ck = ~o_ck;
  end

  // Idle pins; the clock gate stays high throughout the run.
  initial begin
    o_cke = 1'b1;
    {o_cs_n, o_act_n, o_ras_n, o_cas_n, o_we_n} = 5'h1f;
    {o_bg, o_ba, o_addr} = 22'h000000;
  end

  // Counts link edges so the bench can measure command delays.
  always @(posedge o_ck) begin
    edges <= edges + 1;
  end

  // Sends one command around a link edge: 0 load, 1 read, 2 write, 3 activate.
  task automatic send(input logic [1:0] kind, input logic [21:0] word);
    logic [2:0] lines;
    lines = kind == 2'h0 ? 3'h0 : kind == 2'h1 ? 3'h5 : kind == 2'h2 ? 3'h4 : 3'h7;
    @(posedge o_ck);
    repeat (6) @(negedge i_clk_sys);
    o_cs_n = 1'b0;
    o_act_n = kind != 2'h3;
    {o_ras_n, o_cas_n, o_we_n} = lines;
    {o_bg, o_ba} = word[21:18];
    o_addr = {word[17], lines, word[13:0]};
    @(posedge o_ck);
    cmd_edge = edges + 1;
    repeat (6) @(negedge i_clk_sys);
    // Deselect and show the inverse of the last word.
    {o_cs_n, o_act_n, o_ras_n, o_cas_n, o_we_n} = 5'h1f;
    {o_bg, o_ba, o_addr} = ~{o_bg, o_ba, o_addr};
  endtask : send
endmodule : mode_load_controller

// ===== test_dram_mode_word_config.sv
`timescale 1ns/10ps

`define CHECK_EQ(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

// ****************************************************************
// Self-checking bench for the mode word block.
// ****************************************************************
module test_dram_mode_word_config;
  import mode_word_pkg::*;
  logic clk_sys, rst_n, term_pin, forb_seen = 1'b0;
  logic [4:0] cl, write_cas_delay, al;
  wire logic ck, cke, cs_n, act_n, ras_n, cas_n, we_n;
  wire logic [1:0] bg, ba;
  wire logic [17:0] addr;
  logic [WORD_W-1:0] second_w, third_w, sixth_w;
  logic dll_en, drv_en, wlev, crc, st_en, stp_en, mask_en, winv, rinv, rd_iss, wr_iss, forb;
  logic [1:0] drv;
  logic [5:0] ohm, rl, wl;
  logic [2:0] eq, tcode;
  logic [3:0] tsrc;
  int fail_count = 0, cmp_count = 0, cycles = 0, n, k;
  logic [5:0] ohm_tab [4] = '{6'h22, 6'h30, 6'h00, 6'h00}; // Ohms per drive code.
  logic [4:0] al_tab [4] = '{5'h00, 5'h0a, 5'h09, 5'h00}; // Added latency, read CAS 11.

  mode_load_controller ctl (.i_clk_sys(clk_sys), .o_ck(ck), .o_cke(cke), .o_cs_n(cs_n),
    .o_act_n(act_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_bg(bg), .o_ba(ba),
    .o_addr(addr));

  dram_mode_word_config dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_ck(ck), .i_cke(cke),
    .i_cs_n(cs_n), .i_act_n(act_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
    .i_bg(bg), .i_ba(ba), .i_addr(addr), .i_termination_enable_pin(term_pin),
    .i_read_cas_delay(cl), .i_write_cas_delay(write_cas_delay), .o_second_mode_word(second_w),
    .o_third_mode_word(third_w), .o_sixth_mode_word(sixth_w), .o_dll_enable(dll_en),
    .o_driver_strength(drv), .o_driver_ohm(ohm), .o_driver_enable(drv_en),
    .o_added_latency(al), .o_read_latency(rl), .o_write_latency(wl),
    .o_receiver_equalizer(eq), .o_write_level(wlev), .o_crc_enable(crc),
    .o_strobe_term_en(st_en), .o_strobe_pin_term_en(stp_en), .o_byte_write_mask_en(mask_en),
    .o_write_inv_en(winv), .o_read_inv_en(rinv), .o_term_src(tsrc), .o_term_code(tcode),
    .o_rd_issue(rd_iss), .o_wr_issue(wr_iss), .o_forbidden_load(forb));

  // System clock, 25 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Builds a pin word from a select code and the low fourteen bits.
  function automatic logic [21:0] mk(input logic [2:0] sel, input logic [13:0] lo);
    return {1'b0, sel, 4'h0, lo};
  endfunction : mk

  // Loads one mode word, then lets derived outputs settle.
  task automatic load(input logic [2:0] sel, input logic [13:0] lo);
    ctl.send(2'h0, mk(sel, lo));
    repeat (4) @(negedge clk_sys);
  endtask : load

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // Cuts a hang short and remembers any forbidden load pulse.
  always @(posedge clk_sys) begin
    cycles++;
    if (forb === 1'b1) forb_seen <= 1'b1;
    if (cycles > 6000) begin
      fail_count++;
      complete_run();
    end
  end

  // Main sequence.
  initial begin
    {rst_n, term_pin} = 2'b01;
    cl = 5'h0b;
    write_cas_delay = 5'h09;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    `CHECK_EQ({second_w, third_w, dll_en, drv_en, tsrc}, {44'h0, 1'b0, 1'b1, TS_NONE});
    repeat (8) @(negedge clk_sys);
    // Drive strength, added latency and equalizer codes.
    for (int i = 0; i < 4; i++) begin
      load(SEL_SECOND, 14'(1 + 42 * i));
      `CHECK_EQ(second_w, mk(SEL_SECOND, 14'(1 + 42 * i)));
      `CHECK_EQ({drv, ohm, eq}, {2'(i), ohm_tab[i], 3'(i)});
      `CHECK_EQ(al, al_tab[i]);
      `CHECK_EQ({rl, wl}, {6'(al_tab[i]) + 6'h0b, 6'(al_tab[i]) + 6'h09});
    end
    // Equalizer, leveling, strobe termination and the shared pin.
    load(SEL_SECOND, 14'h28a1);
    load(SEL_SIXTH, 14'h1c00);
    `CHECK_EQ({eq, wlev, st_en, stp_en}, {3'h5, 1'b1, 1'b1, 1'b0});
    `CHECK_EQ({mask_en, winv, rinv, sixth_w}, {3'h0, mk(SEL_SIXTH, 14'h1c00)});
    load(SEL_SECOND, 14'h0001);
    `CHECK_EQ({mask_en, winv, rinv}, 3'h5);
    // Third word holds CRC and write termination; second word untouched.
    load(SEL_THIRD, 14'h1200);
    `CHECK_EQ({crc, third_w}, {1'b1, mk(SEL_THIRD, 14'h1200)});
    `CHECK_EQ(second_w, mk(SEL_SECOND, 14'h0001));
    // Forbidden select leaves the second and third words as they were.
    load(SEL_FORBIDDEN, 14'h3fff);
    `CHECK_EQ({forb_seen, second_w, third_w}, {1'b1, mk(SEL_SECOND, 14'h0001),
      mk(SEL_THIRD, 14'h1200)});
    // Nominal with the pin high, park with it low.
    load(SEL_SIXTH, 14'h0080);
    load(SEL_SECOND, 14'h0301);
    `CHECK_EQ({tsrc, tcode}, {TS_NOM, 3'h3});
    term_pin = 1'b0;
    repeat (10) @(negedge clk_sys);
    `CHECK_EQ({tsrc, tcode}, {TS_PARK, 3'h2});
    // Commands held back by the added latency, nominal termination off.
    cl = 5'h03;
    for (int j = 0; j < 3; j++) begin
      load(SEL_SECOND, 14'(1 + (((j + 1) % 3) << 3)));
      ctl.send(2'h3, 22'h000000);
      fork
        ctl.send(j == 1 ? 2'h2 : 2'h1, 22'h000000);
        begin
          for (k = 0; k < 120; k++) begin
            @(negedge clk_sys);
            if ((j == 1 ? wr_iss : rd_iss) === 1'b1) break;
          end
          n = ctl.edges - ctl.cmd_edge;
          `CHECK_EQ({k < 120, 5'(n)}, {1'b1, j == 0 ? 5'h02 : j == 1 ? 5'h01 : 5'h00});
          repeat (3) @(negedge clk_sys);
          if (j == 1) `CHECK_EQ(tsrc, TS_WRITE);
        end
      join
    end
    // Output disable disconnects drivers and termination.
    load(SEL_SECOND, 14'h1001);
    `CHECK_EQ({drv_en, tsrc}, {1'b0, TS_NONE});
    complete_run();
  end
endmodule : test_dram_mode_word_config
